// >>> rtl/uisc_defs.svh
// Register offsets, field positions, reset values and timing counts for the interrupt/sleep/modem block
`ifndef UISC_DEFS_SVH
`define UISC_DEFS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define UISC_OFF_IEM      8'h00
`define UISC_OFF_ISC      8'h04
`define UISC_OFF_MLC      8'h08
`define UISC_OFF_MSW      8'h0C
`define UISC_OFF_CFG      8'h10
`define UISC_OFF_STAT     8'h14

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define UISC_IEM_RXDATA   0
`define UISC_IEM_TXEMPTY  1
`define UISC_IEM_RXSTAT   2
`define UISC_IEM_MODEM    3
`define UISC_IEM_SLEEP    4
`define UISC_IEM_SPECIAL  5
`define UISC_IEM_RTS      6
`define UISC_IEM_CTS      7
`define UISC_MLC_DTR      0
`define UISC_MLC_RTS      1
`define UISC_MLC_AUXA     2
`define UISC_MLC_AUXB     3
`define UISC_MLC_LOOP     4
`define UISC_MLC_IRDA     6
`define UISC_CFG_ENH      0
`define UISC_CFG_NINE     1
`define UISC_CFG_NINEADR  2
`define UISC_CFG_FIFOEN   3
`define UISC_CFG_EXTTRIG  4
`define UISC_CFG_INBAND   5
`define UISC_CFG_SPECDET  6
`define UISC_CFG_MODE650  7
`define UISC_CFG_MODE750  8
`define UISC_CFG_DEEP     9

// ---------------------------------------------------------------
// Reset values and codes
// ---------------------------------------------------------------
`define UISC_IEM_RST      8'h00
`define UISC_MLC_RST      8'h00
`define UISC_CFG_RST      10'h000
`define UISC_CODE_NONE    6'h01
`define UISC_CODE_L1      6'h06
`define UISC_CODE_L2A     6'h04
`define UISC_CODE_L2B     6'h0C
`define UISC_CODE_L3      6'h02
`define UISC_CODE_L4      6'h00
`define UISC_CODE_L5      6'h10
`define UISC_CODE_L6      6'h20

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define UISC_TIMEOUT_CHARS 4

`endif

// >>> rtl/uisc_pkg.sv
// Types shared by the interrupt/sleep/modem block
package uisc_pkg;
    typedef enum logic [1:0] {
        UISC_APB_IDLE   = 2'b00,
        UISC_APB_ACCESS = 2'b01
    } uisc_apb_e;
    typedef logic [5:0] uisc_code_t;
endpackage

// >>> rtl/uisc_core.sv
// UART interrupt priority, sleep control, modem outputs and loopback with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "uisc_defs.svh"

// Contract
// [R01] Code shows highest pending of six levels; 000001 when idle.
// [R02] Levels 5 and 6 only raised in enhanced mode.
// [R03] Code bit 5 per mode: level 6, FIFO depth in 750 mode, else 0.
// [R04] Normal framing: level 1 from line errors, enabled by mask bit 2.
// [R05] Nine-bit: errors enabled by mask bit 3, address bit by nine-bit control.
// [R06] Level 2a while receive level above trigger.
// [R07] Level 2b needs FIFO mode, data held, and idle past time-out.
// [R08] Time-out is four characters; first receive read clears it.
// [R09] Level 3 sets below trigger; clears on code read or refill.
// [R10] Extended trigger zero waits for transmitter fully idle.
// [R11] Level 4 from modem delta flags; cleared by modem status read.
// [R12] Level 5 from stop, alternate stop or special char; cleared by code read.
// [R13] Level 6 on CTS or RTS rising; cleared by code read.
// [R14] Mask bit 7 gates CTS change only in enhanced mode.
// [R15] Clock gated only when every sleep precondition holds.
// [R16] Sleep bit reads back whether power-down took effect.
// [R17] Leave sleep when any precondition fails or request clears.
// [R18] No sleep while infrared mode selected.
// [R19] Control bits drive DTR/RTS low-active, aux outputs high when set.
// [R20] Drive select low: bit 3 enables interrupt driver; high: always driven.
// [R21] Loopback: outputs high, inputs ignored, outputs feed inputs internally; code still takes the level 6 CTS rise from the cts_in_n pin.
// [R22] Loopback modem interrupts come from control bits, still masked.
// [R23] Delta flags set on change, RI on rise; kept until status read.
// [R24] Interrupt output follows any enabled pending source every cycle.
module uisc_core #(
    parameter int TIMEOUT_CHARS = `UISC_TIMEOUT_CHARS
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Status from the UART datapath (same clock)
    input  wire logic [3:0]  line_err,
    input  wire logic        rx_addr_bit,
    input  wire logic        line_status_read,
    input  wire logic        rx_above_trig,
    input  wire logic        rx_data_held,
    input  wire logic        rx_read,
    input  wire logic        rx_write,
    input  wire logic        char_tick,
    input  wire logic        tx_below_trig,
    input  wire logic        tx_above_trig,
    input  wire logic        tx_trig_zero,
    input  wire logic        tx_idle,
    input  wire logic        rx_idle,
    input  wire logic        stop_char_hit,
    input  wire logic        alt_stop_char_hit,
    input  wire logic        special_hit,
    input  wire logic        tx_serial,
    // Line pins (asynchronous)
    input  wire logic        serial_in,
    input  wire logic        cts_in_n,
    input  wire logic        dsr_in_n,
    input  wire logic        ri_in_n,
    input  wire logic        dcd_in_n,
    input  wire logic        irq_drive_select_n,
    // Line outputs
    output logic             serial_out,
    output logic             dtr_out_n,
    output logic             rts_out_n,
    output logic             aux_out_a_n,
    output logic             aux_out_b_n,
    output logic             irq_out,
    output logic             irq_oe_n,
    output logic             rx_serial,
    output logic             clk_gate_off
);

    // ---------------------------------------------------------------
    // Parameter check
    // ---------------------------------------------------------------
    initial begin
        if (TIMEOUT_CHARS < 1 || TIMEOUT_CHARS > 15) begin
            $error("TIMEOUT_CHARS out of range");
        end
    end

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [5:0] pin_s1_reg;
    logic [5:0] pin_s2_reg;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_s1_reg <= 6'h3F;
            pin_s2_reg <= 6'h3F;
        end else begin
            pin_s1_reg <= {irq_drive_select_n, serial_in, dcd_in_n, ri_in_n, dsr_in_n, cts_in_n};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [7:0]  iem_reg;
    logic [7:0]  mlc_reg;
    logic [9:0]  cfg_reg;
    logic [3:0]  delta_reg;
    logic [3:0]  mstate_reg;
    logic        l3_reg;
    logic        l5_reg;
    logic        l6_reg;
    logic [1:0]  flow_prev_reg;
    logic [3:0]  tout_cnt_reg;
    logic        tout_reg;
    logic        sleep_reg;
    uisc_pkg::uisc_apb_e apb_reg;

    wire enh   = cfg_reg[`UISC_CFG_ENH];
    wire nine  = cfg_reg[`UISC_CFG_NINE];
    wire loop  = mlc_reg[`UISC_MLC_LOOP];

    wire wr_acc = psel && penable && pwrite && (apb_reg == uisc_pkg::UISC_APB_ACCESS);
    wire rd_acc = psel && penable && !pwrite && (apb_reg == uisc_pkg::UISC_APB_ACCESS);
    wire mapped = (paddr <= `UISC_OFF_STAT) && (paddr[1:0] == 2'b00);
    wire wr_iem = wr_acc && paddr == `UISC_OFF_IEM;
    wire wr_mlc = wr_acc && paddr == `UISC_OFF_MLC;
    wire wr_cfg = wr_acc && paddr == `UISC_OFF_CFG;
    wire rd_isc = rd_acc && paddr == `UISC_OFF_ISC;
    wire rd_msw = rd_acc && paddr == `UISC_OFF_MSW;

    // ---------------------------------------------------------------
    // Modem inputs (active high), loopback substitution
    // ---------------------------------------------------------------
    // [R21] loopback internal feed
    wire [3:0] pin_act  = ~{pin_s2_reg[3], pin_s2_reg[2], pin_s2_reg[1], pin_s2_reg[0]};
    wire [3:0] loop_act = {mlc_reg[`UISC_MLC_AUXB], mlc_reg[`UISC_MLC_AUXA],
                           mlc_reg[`UISC_MLC_DTR], mlc_reg[`UISC_MLC_RTS]};
    // [R22] loopback modem source
    wire [3:0] m_now    = loop ? loop_act : pin_act;
    wire [3:0] m_chg    = m_now ^ mstate_reg;
    // [R23] delta detection, RI on rise
    wire [3:0] m_evt    = {m_chg[3], m_chg[2] & ~m_now[2], m_chg[1], m_chg[0]};
    wire [3:0] delta_next = m_evt | (rd_msw ? 4'h0 : delta_reg);
    wire       sin_eff  = loop ? tx_serial : pin_s2_reg[4];

    // ---------------------------------------------------------------
    // Source conditions
    // ---------------------------------------------------------------
    // [R04] normal framing level 1
    wire l1_norm = (|line_err) && iem_reg[`UISC_IEM_RXSTAT];
    // [R05] nine-bit level 1 masking
    wire l1_nine = ((line_err[0] | line_err[2] | line_err[3]) && iem_reg[`UISC_IEM_MODEM])
                 || (rx_addr_bit && cfg_reg[`UISC_CFG_NINEADR]);
    wire p1  = nine ? l1_nine : l1_norm;
    // [R06] receive data level
    wire p2a = rx_above_trig && iem_reg[`UISC_IEM_RXDATA];
    wire p2b = tout_reg && iem_reg[`UISC_IEM_RXDATA];
    wire p3  = l3_reg && iem_reg[`UISC_IEM_TXEMPTY];
    // [R11] modem change level
    wire p4  = (|delta_reg) && iem_reg[`UISC_IEM_MODEM];
    // [R02] enhanced-only levels
    wire p5  = enh && l5_reg;
    wire p6  = enh && l6_reg;

    // [R01] priority encoding
    wire [5:0] code_pri = p1  ? `UISC_CODE_L1  :
                          p2a ? `UISC_CODE_L2A :
                          p2b ? `UISC_CODE_L2B :
                          p3  ? `UISC_CODE_L3  :
                          p4  ? `UISC_CODE_L4  :
                          p5  ? `UISC_CODE_L5  :
                          p6  ? `UISC_CODE_L6  : `UISC_CODE_NONE;
    // [R03] bit 5 by mode
    wire bit5 = cfg_reg[`UISC_CFG_MODE750] ? cfg_reg[`UISC_CFG_DEEP] :
                cfg_reg[`UISC_CFG_MODE650] ? code_pri[5] : 1'b0;
    wire [5:0] code_rd = {bit5, code_pri[4:0]};
    wire any_pend = p1 | p2a | p2b | p3 | p4 | p5 | p6;

    // ---------------------------------------------------------------
    // Level 3, 5, 6 latches
    // ---------------------------------------------------------------
    // [R10] zero trigger waits for idle line
    wire l3_set = (cfg_reg[`UISC_CFG_EXTTRIG] && tx_trig_zero) ? (tx_idle && tx_serial)
                                                              : tx_below_trig;
    // [R09] level 3 clear by read or refill
    wire l3_clr = (rd_isc && code_pri == `UISC_CODE_L3) || tx_above_trig;
    wire l3_next = l3_set || (l3_reg && !l3_clr);
    // [R12] level 5 causes
    wire l5_set = enh && ((stop_char_hit && cfg_reg[`UISC_CFG_INBAND])
                || (alt_stop_char_hit && cfg_reg[`UISC_CFG_SPECDET])
                || (nine && special_hit)) && iem_reg[`UISC_IEM_SPECIAL];
    wire l5_next = l5_set || (l5_reg && !(rd_isc && code_pri == `UISC_CODE_L5));
    // [R13] CTS/RTS rising
    wire [1:0] flow_now = {pin_s2_reg[0], rts_out_n};
    wire       cts_rise = flow_now[1] & ~flow_prev_reg[1];
    wire       rts_rise = flow_now[0] & ~flow_prev_reg[0];
    // [R14] CTS mask only in enhanced mode
    wire cts_en  = enh ? iem_reg[`UISC_IEM_CTS] : 1'b1;
    wire l6_set  = (cts_rise && cts_en) || (rts_rise && iem_reg[`UISC_IEM_RTS]);
    wire l6_next = l6_set || (l6_reg && !(rd_isc && code_pri == `UISC_CODE_L6));

    // ---------------------------------------------------------------
    // Receive time-out
    // ---------------------------------------------------------------
    // [R07] time-out conditions
    wire tout_arm  = cfg_reg[`UISC_CFG_FIFOEN] && rx_data_held;
    // [R08] four character periods, read clears
    wire [3:0] tout_cnt_next = (!tout_arm || rx_read || rx_write) ? 4'h0 :
                               (char_tick && tout_cnt_reg != TIMEOUT_CHARS[3:0])
                               ? tout_cnt_reg + 4'h1 : tout_cnt_reg;
    wire tout_next = tout_arm && !rx_read && !rx_write
                   && (tout_cnt_next == TIMEOUT_CHARS[3:0]);

    // ---------------------------------------------------------------
    // Sleep
    // ---------------------------------------------------------------
    wire sleep_req = cfg_reg[`UISC_CFG_MODE750] && !enh ? iem_reg[`UISC_IEM_SPECIAL]
                                                        : iem_reg[`UISC_IEM_SLEEP];
    // [R15] all sleep preconditions
    // [R18] no sleep in infrared mode
    // [R17] auto wake when any fails
    wire sleep_next = sleep_req && tx_idle && sin_eff && rx_idle && !rx_data_held
                    && !loop && delta_reg == 4'h0 && !any_pend
                    && !mlc_reg[`UISC_MLC_IRDA];

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            iem_reg       <= `UISC_IEM_RST;
            mlc_reg       <= `UISC_MLC_RST;
            cfg_reg       <= `UISC_CFG_RST;
            delta_reg     <= 4'h0;
            mstate_reg    <= 4'h0;
            l3_reg        <= 1'b0;
            l5_reg        <= 1'b0;
            l6_reg        <= 1'b0;
            flow_prev_reg <= 2'b11;
            tout_cnt_reg  <= 4'h0;
            tout_reg      <= 1'b0;
            sleep_reg     <= 1'b0;
        end else begin
            if (wr_iem) iem_reg <= pwdata[7:0];
            if (wr_mlc) mlc_reg <= pwdata[7:0];
            if (wr_cfg) cfg_reg <= pwdata[9:0];
            delta_reg     <= delta_next;
            mstate_reg    <= m_now;
            l3_reg        <= l3_next;
            l5_reg        <= l5_next;
            l6_reg        <= l6_next;
            flow_prev_reg <= flow_now;
            tout_cnt_reg  <= tout_cnt_next;
            tout_reg      <= tout_next;
            sleep_reg     <= sleep_next;
        end
    end

    // ---------------------------------------------------------------
    // APB read and handshake
    // ---------------------------------------------------------------
    // [R16] sleep bit shows power-down state
    wire [7:0] iem_rd = !sleep_req ? iem_reg :
                        (cfg_reg[`UISC_CFG_MODE750] && !enh)
                        ? {iem_reg[7:6], sleep_reg, iem_reg[4:0]}
                        : {iem_reg[7:5], sleep_reg, iem_reg[3:0]};
    wire [31:0] rd_mux = (paddr == `UISC_OFF_IEM)  ? {24'h000000, iem_rd} :
                         (paddr == `UISC_OFF_ISC)  ? {26'h0000000, code_rd} :
                         (paddr == `UISC_OFF_MLC)  ? {24'h000000, mlc_reg} :
                         (paddr == `UISC_OFF_MSW)  ? {24'h000000, m_now, delta_reg} :
                         (paddr == `UISC_OFF_CFG)  ? {22'h000000, cfg_reg} :
                         (paddr == `UISC_OFF_STAT) ? {30'h00000000, any_pend, sleep_reg} :
                         32'h00000000;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            apb_reg <= uisc_pkg::UISC_APB_IDLE;
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            apb_reg <= (psel && !penable) ? uisc_pkg::UISC_APB_ACCESS
                                          : uisc_pkg::UISC_APB_IDLE;
            if (psel && !penable && !pwrite) prdata <= mapped ? rd_mux : 32'h00000000;
        end
    end

    // ---------------------------------------------------------------
    // Line outputs
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            serial_out   <= 1'b1;
            dtr_out_n    <= 1'b1;
            rts_out_n    <= 1'b1;
            aux_out_a_n  <= 1'b1;
            aux_out_b_n  <= 1'b1;
            irq_out      <= 1'b0;
            irq_oe_n     <= 1'b1;
            rx_serial    <= 1'b1;
            clk_gate_off <= 1'b0;
        end else begin
            // [R19] control bits onto pins
            // [R21] outputs inactive in loopback
            serial_out   <= loop ? 1'b1 : tx_serial;
            dtr_out_n    <= loop ? 1'b1 : ~mlc_reg[`UISC_MLC_DTR];
            rts_out_n    <= loop ? 1'b1 : ~mlc_reg[`UISC_MLC_RTS];
            aux_out_a_n  <= loop ? 1'b1 : mlc_reg[`UISC_MLC_AUXA];
            aux_out_b_n  <= loop ? 1'b1 : mlc_reg[`UISC_MLC_AUXB];
            // [R24] interrupt follows pending
            irq_out      <= any_pend;
            // [R20] driver enable select
            irq_oe_n     <= pin_s2_reg[5] ? 1'b0 : ~mlc_reg[`UISC_MLC_AUXB];
            rx_serial    <= sin_eff;
            clk_gate_off <= sleep_next;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_idle_code;
        @(posedge ref_clk) disable iff (!rst_n)
        !any_pend |-> code_pri == `UISC_CODE_NONE;
    endproperty
    a_idle_code: assert property (p_idle_code) else $error("idle code wrong"); // [R01]

    property p_enh_only;
        @(posedge ref_clk) disable iff (!rst_n)
        !enh |-> code_pri != `UISC_CODE_L5 && code_pri != `UISC_CODE_L6;
    endproperty
    a_enh_only: assert property (p_enh_only) else $error("level 5/6 outside enhanced"); // [R02]

    property p_irq_follow;
        @(posedge ref_clk) disable iff (!rst_n)
        any_pend |=> irq_out;
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("irq not raised"); // [R24]

    property p_no_sleep_irda;
        @(posedge ref_clk) disable iff (!rst_n)
        mlc_reg[`UISC_MLC_IRDA] |=> !clk_gate_off;
    endproperty
    a_no_sleep_irda: assert property (p_no_sleep_irda) else $error("sleep in infrared"); // [R18]

    property p_loop_out;
        @(posedge ref_clk) disable iff (!rst_n)
        loop |=> serial_out && dtr_out_n && rts_out_n && aux_out_a_n && aux_out_b_n;
    endproperty
    a_loop_out: assert property (p_loop_out) else $error("loopback outputs active"); // [R21]

    property p_delta_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (|delta_reg) && !rd_msw |=> (delta_reg & $past(delta_reg)) == $past(delta_reg);
    endproperty
    a_delta_hold: assert property (p_delta_hold) else $error("delta lost"); // [R23]

    property p_sleep_wake;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_gate_off && !sleep_req |=> !clk_gate_off;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("no wake"); // [R17]

    property p_irq_drive;
        @(posedge ref_clk) disable iff (!rst_n)
        pin_s2_reg[5] |=> !irq_oe_n;
    endproperty
    a_irq_drive: assert property (p_irq_drive) else $error("irq not driven"); // [R20]

endmodule
`default_nettype wire

// >>> sim/uisc_modem_model.sv
// Far-side modem line model driving the UART modem and serial pins
`timescale 1ns/1ps
`default_nettype none
module uisc_modem_model (
    // Clock
    input  wire logic       ref_clk,
    // Wanted line levels {dcd, ri, dsr, cts}, low = asserted
    input  wire logic [3:0] want_n,
    // Pins toward the UART
    output logic            cts_in_n,
    output logic            dsr_in_n,
    output logic            ri_in_n,
    output logic            dcd_in_n,
    output logic            serial_in
);
    // Lines change only just after an edge
    always_ff @(posedge ref_clk) begin
        {dcd_in_n, ri_in_n, dsr_in_n, cts_in_n} <= want_n;
    end
    // Serial line held at idle marking
    assign serial_in = 1'h1;
endmodule
`default_nettype wire

// >>> sim/uart_irq_sleep_modem_ctrl_bench.sv
// Self-checking bench for the interrupt, sleep and modem block
`timescale 1ns/1ps
`default_nettype none
`include "uisc_defs.svh"
module uart_irq_sleep_modem_ctrl_bench;
    logic ref_clk = 1'h0, rst_n = 1'h0, perr;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [3:0] line_err = 4'h0, want_n = 4'hF;
    logic rx_addr_bit, line_status_read, rx_above_trig, rx_data_held, rx_read;
    logic rx_write, char_tick, tx_below_trig, tx_above_trig, tx_trig_zero;
    logic stop_char_hit, alt_stop_char_hit, special_hit;
    logic tx_idle = 1'h1, rx_idle = 1'h1, tx_serial = 1'h1, irq_drive_select_n = 1'h1;
    logic serial_in, cts_in_n, dsr_in_n, ri_in_n, dcd_in_n, rx_serial, clk_gate_off;
    logic serial_out, dtr_out_n, rts_out_n, aux_out_a_n, aux_out_b_n, irq_out, irq_oe_n;
    int errors = 0, checks = 0;

    always #4 ref_clk = ~ref_clk;

    uisc_core uisc_core_i (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .line_err, .rx_addr_bit, .line_status_read,
        .rx_above_trig, .rx_data_held, .rx_read, .rx_write, .char_tick, .tx_below_trig,
        .tx_above_trig, .tx_trig_zero, .tx_idle, .rx_idle, .stop_char_hit,
        .alt_stop_char_hit, .special_hit, .tx_serial, .serial_in, .cts_in_n, .dsr_in_n,
        .ri_in_n, .dcd_in_n, .irq_drive_select_n, .serial_out, .dtr_out_n, .rts_out_n,
        .aux_out_a_n, .aux_out_b_n, .irq_out, .irq_oe_n, .rx_serial, .clk_gate_off);
    uisc_modem_model uisc_modem_model_i (.ref_clk, .want_n, .cts_in_n, .dsr_in_n,
        .ri_in_n, .dcd_in_n, .serial_in);

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        q = prdata;
        perr = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(1'h0, a, 32'h0);
        chk(q & m, e);
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic cts_rise;
        want_n <= 4'hE;
        idle(6);
        want_n <= 4'hF;
        idle(6);
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        {rx_addr_bit, line_status_read, rx_above_trig, rx_data_held, rx_read, rx_write,
         char_tick, tx_below_trig, tx_above_trig, tx_trig_zero, stop_char_hit,
         alt_stop_char_hit, special_hit} = 13'h0;
        idle(10);
        rst_n <= 1'h1;
        rd(`UISC_OFF_IEM, 32'hFF, 32'h00);
        rd(`UISC_OFF_MLC, 32'hFF, 32'h00);
        rd(`UISC_OFF_ISC, 32'h3F, 32'h01);
        rd(8'h40, 32'hFFFFFFFF, 32'h0);
        chk(perr, 1'h1);
        wr(`UISC_OFF_MLC, 32'h0F);
        idle(2);
        chk({dtr_out_n, rts_out_n, aux_out_a_n, aux_out_b_n}, 4'h3);
        irq_drive_select_n <= 1'h0;
        idle(5);
        chk(irq_oe_n, 1'h0);
        wr(`UISC_OFF_MLC, 32'h07);
        idle(2);
        chk(irq_oe_n, 1'h1);
        irq_drive_select_n <= 1'h1;
        idle(5);
        chk(irq_oe_n, 1'h0);
        wr(`UISC_OFF_MLC, 32'h10);
        rd(`UISC_OFF_MSW, 32'hFF, 32'h00);
        wr(`UISC_OFF_MLC, 32'h1F);
        tx_serial <= 1'h0;
        idle(2);
        chk({serial_out, dtr_out_n, rts_out_n, aux_out_a_n, aux_out_b_n}, 5'h1F);
        chk(rx_serial, 1'h0);
        tx_serial <= 1'h1;
        wr(`UISC_OFF_IEM, 32'h08);
        rd(`UISC_OFF_ISC, 32'h3F, 32'h00);
        rd(`UISC_OFF_MSW, 32'hFF, 32'hFB);
        rd(`UISC_OFF_ISC, 32'h3F, 32'h01);
        wr(`UISC_OFF_MLC, 32'h00);
        rd(`UISC_OFF_MSW, 32'hFF, 32'h0F);
        wr(`UISC_OFF_IEM, 32'h07);
        rx_above_trig <= 1'h1;
        idle(2);
        rd(`UISC_OFF_ISC, 32'h3F, 32'h04);
        chk(irq_out, 1'h1);
        line_err <= 4'h2;
        idle(2);
        rd(`UISC_OFF_ISC, 32'h3F, 32'h06);
        line_err <= 4'h0;
        rx_above_trig <= 1'h0;
        tx_below_trig <= 1'h1;
        idle(1);
        tx_below_trig <= 1'h0;
        idle(2);
        rd(`UISC_OFF_ISC, 32'h3F, 32'h02);
        rd(`UISC_OFF_ISC, 32'h3F, 32'h01);
        idle(2);
        chk(irq_out, 1'h0);
        wr(`UISC_OFF_CFG, 32'h010);
        {tx_trig_zero, tx_below_trig, tx_serial} <= 3'h6;
        idle(2);
        rd(`UISC_OFF_ISC, 32'h3F, 32'h01);
        tx_serial <= 1'h1;
        idle(2);
        {tx_trig_zero, tx_below_trig} <= 2'h0;
        rd(`UISC_OFF_ISC, 32'h3F, 32'h02);
        rd(`UISC_OFF_ISC, 32'h3F, 32'h01);
        wr(`UISC_OFF_CFG, 32'h089);
        wr(`UISC_OFF_IEM, 32'h01);
        rx_data_held <= 1'h1;
        repeat (5) begin
            char_tick <= 1'h1;
            idle(1);
            char_tick <= 1'h0;
            idle(1);
        end
        rd(`UISC_OFF_ISC, 32'h3F, 32'h0C);
        rx_read <= 1'h1;
        idle(1);
        rx_read <= 1'h0;
        rd(`UISC_OFF_ISC, 32'h3F, 32'h01);
        rx_data_held <= 1'h0;
        wr(`UISC_OFF_CFG, 32'h000);
        wr(`UISC_OFF_IEM, 32'h80);
        cts_rise();
        rd(`UISC_OFF_ISC, 32'h3F, 32'h01);
        wr(`UISC_OFF_CFG, 32'h081);
        cts_rise();
        rd(`UISC_OFF_ISC, 32'h3F, 32'h20);
        rd(`UISC_OFF_ISC, 32'h3F, 32'h01);
        wr(`UISC_OFF_IEM, 32'h00);
        cts_rise();
        rd(`UISC_OFF_ISC, 32'h3F, 32'h01);
        wr(`UISC_OFF_CFG, 32'h300);
        rd(`UISC_OFF_ISC, 32'h3F, 32'h21);
        wr(`UISC_OFF_CFG, 32'h100);
        rd(`UISC_OFF_ISC, 32'h3F, 32'h01);
        wr(`UISC_OFF_CFG, 32'h0A1);
        wr(`UISC_OFF_IEM, 32'h20);
        stop_char_hit <= 1'h1;
        idle(1);
        stop_char_hit <= 1'h0;
        rd(`UISC_OFF_ISC, 32'h3F, 32'h10);
        rd(`UISC_OFF_ISC, 32'h3F, 32'h01);
        rd(`UISC_OFF_MSW, 32'hFF, 32'h01);
        wr(`UISC_OFF_CFG, 32'h006);
        wr(`UISC_OFF_IEM, 32'h04);
        line_err <= 4'h4;
        rd(`UISC_OFF_ISC, 32'h3F, 32'h01);
        wr(`UISC_OFF_IEM, 32'h08);
        rd(`UISC_OFF_ISC, 32'h3F, 32'h06);
        line_err <= 4'h2;
        rd(`UISC_OFF_ISC, 32'h3F, 32'h01);
        {line_err, rx_addr_bit} <= 5'h01;
        rd(`UISC_OFF_ISC, 32'h3F, 32'h06);
        rx_addr_bit <= 1'h0;
        wr(`UISC_OFF_CFG, 32'h081);
        wr(`UISC_OFF_IEM, 32'h10);
        idle(4);
        chk(clk_gate_off, 1'h1);
        rd(`UISC_OFF_IEM, 32'h10, 32'h10);
        rx_data_held <= 1'h1;
        idle(2);
        chk(clk_gate_off, 1'h0);
        rd(`UISC_OFF_IEM, 32'h10, 32'h00);
        rx_data_held <= 1'h0;
        idle(4);
        chk(clk_gate_off, 1'h1);
        wr(`UISC_OFF_IEM, 32'h00);
        idle(2);
        chk(clk_gate_off, 1'h0);
        wr(`UISC_OFF_MLC, 32'h40);
        wr(`UISC_OFF_IEM, 32'h10);
        idle(4);
        chk(clk_gate_off, 1'h0);
        test_done();
    end

    // Hang guard
    initial begin
        #300000;
        errors++;
        test_done();
    end
endmodule
`default_nettype wire
